// ### pco_position_compare.sv
// Position compare output engine with its Avalon-MM register file
`timescale 1ns/100ps
module pco_position_compare
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [7:0]                 avAddress,
   input  wire logic                       avRead,
   input  wire logic                       avWrite,
   input  wire logic [31:0]                avWriteData,
   output logic      [31:0]                avReadData,
   output logic                            avWaitRequest,
   input  wire logic [31:0]                posIn,
   output logic                            cmpOut,
   output logic      [pco_pkg::NPINS-1:0]  pinOut
);
   // ======================================================
   // Register file
   pco_pkg::pco_cfg_t cfg, next_cfg;
   logic              en, next_en, ack, next_ack, originSet;
   logic [31:0]       next_rdData;
   logic [2:0]        ptAttr [pco_pkg::NPTS];
   logic [2:0]        next_ptAttr [pco_pkg::NPTS];
   logic [31:0]       ptTgt [pco_pkg::NPTS];
   logic [31:0]       next_ptTgt [pco_pkg::NPTS];
   logic [7:0]        ptOff;
   logic              inPt;
   pco_pkg::pco_state_t state, next_state;
   logic [4:0]        idx, next_idx;
   logic signed [31:0] pos, next_pos;
   logic              lvl, next_lvl;
   logic              pend;
   logic              actv;

   assign avWaitRequest = (avRead | avWrite) & ~ack;
   assign ptOff = avAddress - pco_pkg::A_PT;
   assign inPt  = (avAddress >= pco_pkg::A_PT) && (avAddress < pco_pkg::A_PTEND);

   always_comb
   begin
      next_cfg    = cfg;
      next_en     = en;
      next_ptAttr = ptAttr;
      next_ptTgt  = ptTgt;
      next_ack    = (avRead | avWrite) & ~ack;
      next_rdData = '0;
      originSet   = 1'b0;
      if (avWrite && ack)
      begin
         if (inPt && ptOff[pco_pkg::PT_TGT_SEL])
            next_ptTgt[ptOff[7:3]] = avWriteData;
         else if (inPt)
            next_ptAttr[ptOff[7:3]] = avWriteData[2:0];
         else
            case (avAddress)
               pco_pkg::A_CTRL:
               begin
                  next_en   = avWriteData[pco_pkg::CTRL_EN];
                  originSet = avWriteData[pco_pkg::CTRL_ORIGIN];
               end
               pco_pkg::A_MODE:   next_cfg.mode = avWriteData[1:0];
               pco_pkg::A_OUTCFG:
               begin
                  next_cfg.idleHigh  = avWriteData[0];
                  next_cfg.levelForm = avWriteData[1];
               end
               pco_pkg::A_PULSEW: next_cfg.pulseW = avWriteData[13:0];
               pco_pkg::A_DELAY:  next_cfg.delay = avWriteData[7:0];
               pco_pkg::A_ORIGIN: next_cfg.origin = avWriteData;
               pco_pkg::A_START:
                  if (avWriteData[4:0] >= pco_pkg::IDX_MIN && avWriteData[4:0] <= pco_pkg::IDX_MAX)
                     next_cfg.startIdx = avWriteData[4:0];
               pco_pkg::A_END:
                  if (avWriteData[4:0] >= pco_pkg::IDX_MIN && avWriteData[4:0] <= pco_pkg::IDX_MAX)
                     next_cfg.endIdx = avWriteData[4:0];
               pco_pkg::A_RES:
                  if (avWriteData[3:0] <= pco_pkg::RES_MAX)
                     next_cfg.res = avWriteData[3:0];
               pco_pkg::A_PIN:    next_cfg.pinAssign = avWriteData[15:0];
               default: ;
            endcase
      end
      if (avRead && !ack)
      begin
         if (inPt && ptOff[pco_pkg::PT_TGT_SEL])
            next_rdData = ptTgt[ptOff[7:3]];
         else if (inPt)
            next_rdData = {29'h0, ptAttr[ptOff[7:3]]};
         else
            case (avAddress)
               pco_pkg::A_CTRL:   next_rdData = {31'h0, en};
               pco_pkg::A_MODE:   next_rdData = {30'h0, cfg.mode};
               pco_pkg::A_OUTCFG: next_rdData = {30'h0, cfg.levelForm, cfg.idleHigh};
               pco_pkg::A_PULSEW: next_rdData = {18'h0, cfg.pulseW};
               pco_pkg::A_DELAY:  next_rdData = {24'h0, cfg.delay};
               pco_pkg::A_ORIGIN: next_rdData = cfg.origin;
               pco_pkg::A_START:  next_rdData = {27'h0, cfg.startIdx};
               pco_pkg::A_END:    next_rdData = {27'h0, cfg.endIdx};
               pco_pkg::A_RES:    next_rdData = {28'h0, cfg.res};
               pco_pkg::A_PIN:    next_rdData = {16'h0, cfg.pinAssign};
               pco_pkg::A_STATUS:
                  next_rdData = {16'h0, 3'h0, idx, 3'h0, actv, pend, lvl, state[2], state[1]};
               pco_pkg::A_POS:    next_rdData = pos;
               default:           next_rdData = '0;
            endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg <= '{mode: 2'h0, idleHigh: 1'b0, levelForm: 1'b0, pulseW: pco_pkg::PW_DEF,
                  delay: 8'h00, origin: 32'h0, startIdx: pco_pkg::START_DEF,
                  endIdx: pco_pkg::END_DEF, res: pco_pkg::RES_DEF,
                  pinAssign: pco_pkg::PIN_DEF};
         en         <= 1'b0;
         ack        <= 1'b0;
         avReadData <= '0;
         for (int i = 0; i < pco_pkg::NPTS; i++)
         begin
            ptAttr[i] <= pco_pkg::AT_SKIP;
            ptTgt[i]  <= 32'h0;
         end
      end
      else
      begin
         cfg        <= next_cfg;
         en         <= next_en;
         ack        <= next_ack;
         avReadData <= next_rdData;
         ptAttr     <= next_ptAttr;
         ptTgt      <= next_ptTgt;
      end
   end

   // ======================================================
   // Compare engine
   pco_pkg::pco_cfg_t act, next_act;
   logic [2:0]         aAttr [pco_pkg::NPTS];
   logic [2:0]         next_aAttr [pco_pkg::NPTS];
   logic [31:0]        aTgt [pco_pkg::NPTS];
   logic [31:0]        next_aTgt [pco_pkg::NPTS];
   logic signed [31:0] base, next_base, prevScaled, next_prevScaled;
   logic signed [31:0] scaled, curPos, tgt;
   logic               enD, enRise, usTick;
   logic [5:0]         usCnt, next_usCnt;
   logic               next_pend, pendAct, next_pendAct, next_actv;
   logic [7:0]         dcnt, next_dcnt;
   logic [19:0]        wcnt, next_wcnt;
   logic [4:0]         ix;
   logic [2:0]         at;
   logic               fwd, bwd, hit, skip, trig, trigAct, fire, fireAct;
   logic [pco_pkg::NPINS-1:0] next_pins;

   assign enRise = en & ~enD;
   assign usTick = usCnt == 6'(pco_pkg::CYC_US - 1);
   assign ix     = idx - 5'h01;
   assign at     = aAttr[ix];
   assign scaled = $signed(posIn) >>> act.res;
   assign curPos = pos + (scaled - prevScaled);
   assign tgt    = act.mode[pco_pkg::MODE_INC] ? base + $signed(aTgt[ix])
                                               : $signed(aTgt[ix]);
   assign fwd    = (pos < tgt) && (curPos >= tgt);
   assign bwd    = (pos > tgt) && (curPos <= tgt);

   always_comb
   begin
      hit     = 1'b0;
      trigAct = 1'b1;
      skip    = (at == pco_pkg::AT_SKIP) || (at > pco_pkg::AT_IBOTH)
                || (!act.levelForm && at >= pco_pkg::AT_IFWD);
      case (at)
         pco_pkg::AT_FWD, pco_pkg::AT_IFWD:   hit = fwd;
         pco_pkg::AT_BWD, pco_pkg::AT_IBWD:   hit = bwd;
         pco_pkg::AT_BOTH, pco_pkg::AT_IBOTH: hit = fwd | bwd;
         default:                             hit = 1'b0;
      endcase
      if (at >= pco_pkg::AT_IFWD)
         trigAct = 1'b0;
      if (skip)
         hit = 1'b0;
      trig = (state == pco_pkg::S_RUN) && en && !enRise && hit;
   end

   always_comb
   begin
      next_act        = act;
      next_aAttr      = aAttr;
      next_aTgt       = aTgt;
      next_state      = state;
      next_idx        = idx;
      next_pos        = pos;
      next_base       = base;
      next_prevScaled = scaled;
      next_usCnt      = (usTick || trig) ? 6'h00 : usCnt + 6'h01;
      next_pend       = pend;
      next_pendAct    = pendAct;
      next_dcnt       = dcnt;
      next_actv       = actv;
      next_wcnt       = wcnt;
      next_lvl        = lvl;
      fire            = 1'b0;
      fireAct         = trigAct;
      if (enRise)
      begin
         next_act        = cfg;
         next_aAttr      = ptAttr;
         next_aTgt       = ptTgt;
         next_state      = pco_pkg::S_RUN;
         next_idx        = cfg.startIdx;
         next_pos        = cfg.origin;
         next_base       = cfg.origin;
         next_prevScaled = $signed(posIn) >>> cfg.res;
         next_pend       = 1'b0;
         next_actv       = 1'b0;
         next_lvl        = cfg.idleHigh;
      end
      else if (!en)
      begin
         next_state = pco_pkg::S_IDLE;
         next_pend  = 1'b0;
         next_actv  = 1'b0;
         next_lvl   = act.idleHigh;
      end
      else
      begin
         next_pos = originSet ? act.origin : curPos;
         if (state == pco_pkg::S_RUN && (skip || hit))
         begin
            if (hit)
               next_base = tgt;
            if (idx == act.endIdx)
            begin
               if (act.mode[pco_pkg::MODE_CYC])
                  next_idx = act.startIdx;
               else
                  next_state = pco_pkg::S_DONE;
            end
            else
               next_idx = (idx == pco_pkg::IDX_MAX) ? pco_pkg::IDX_MIN : idx + 5'h01;
         end
         if (trig && act.delay == 8'h00)
            fire = 1'b1;
         else if (trig)
         begin
            next_pend    = 1'b1;
            next_pendAct = trigAct;
            next_dcnt    = act.delay;
         end
         else if (pend && usTick)
         begin
            next_dcnt = dcnt - 8'h01;
            if (dcnt == 8'h01)
            begin
               fire      = 1'b1;
               fireAct   = pendAct;
               next_pend = 1'b0;
            end
         end
         if (fire && !act.levelForm)
         begin
            next_actv = 1'b1;
            next_wcnt = 20'(act.pulseW * 20'(pco_pkg::UNIT_US));
            next_lvl  = ~act.idleHigh;
         end
         else if (fire)
            next_lvl = fireAct ? ~act.idleHigh : act.idleHigh;
         else if (actv && usTick)
         begin
            next_wcnt = wcnt - 20'h00001;
            if (wcnt <= 20'h00001)
            begin
               next_actv = 1'b0;
               next_lvl  = act.idleHigh;
            end
         end
      end
      for (int i = 0; i < pco_pkg::NPINS; i++)
         next_pins[i] = (4'(i) == next_act.pinAssign[7:4]) ? next_lvl : 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act <= '{mode: 2'h0, idleHigh: 1'b0, levelForm: 1'b0, pulseW: pco_pkg::PW_DEF,
                  delay: 8'h00, origin: 32'h0, startIdx: pco_pkg::START_DEF,
                  endIdx: pco_pkg::END_DEF, res: pco_pkg::RES_DEF,
                  pinAssign: pco_pkg::PIN_DEF};
         for (int i = 0; i < pco_pkg::NPTS; i++)
         begin
            aAttr[i] <= pco_pkg::AT_SKIP;
            aTgt[i]  <= 32'h0;
         end
         state      <= pco_pkg::S_IDLE;
         idx        <= pco_pkg::START_DEF;
         pos        <= '0;
         base       <= '0;
         prevScaled <= '0;
         enD        <= 1'b0;
         usCnt      <= 6'h00;
         pend       <= 1'b0;
         pendAct    <= 1'b0;
         dcnt       <= 8'h00;
         actv       <= 1'b0;
         wcnt       <= 20'h00000;
         lvl        <= 1'b0;
         pinOut     <= '0;
      end
      else
      begin
         act        <= next_act;
         aAttr      <= next_aAttr;
         aTgt       <= next_aTgt;
         state      <= next_state;
         idx        <= next_idx;
         pos        <= next_pos;
         base       <= next_base;
         prevScaled <= next_prevScaled;
         enD        <= en;
         usCnt      <= next_usCnt;
         pend       <= next_pend;
         pendAct    <= next_pendAct;
         dcnt       <= next_dcnt;
         actv       <= next_actv;
         wcnt       <= next_wcnt;
         lvl        <= next_lvl;
         pinOut     <= next_pins;
      end
   end

   assign cmpOut = lvl;

   // ======================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence runEnd;
      state == pco_pkg::S_RUN && en && !enRise && (skip || hit) && idx == act.endIdx;
   endsequence

   a_enable_loads: assert property (enRise |=> state == pco_pkg::S_RUN
      && idx == $past(cfg.startIdx) && pos == $past(cfg.origin))
      else $error("enable edge did not load settings");
   a_idle_off: assert property (!en |=> lvl == act.idleHigh)
      else $error("output not idle while disabled");
   a_fire_now: assert property (trig && act.delay == 8'h00 && !act.levelForm
      |=> lvl != act.idleHigh && actv)
      else $error("undelayed hit did not drive output");
   a_delay_hold: assert property (trig && act.delay != 8'h00 && !actv
      && lvl == act.idleHigh |=> lvl == act.idleHigh [*2])
      else $error("delayed hit drove output too early");
   a_single_stop: assert property (runEnd and !act.mode[pco_pkg::MODE_CYC]
      |=> state == pco_pkg::S_DONE)
      else $error("single pass did not stop");
   a_cyclic_wrap: assert property (runEnd and act.mode[pco_pkg::MODE_CYC]
      |=> idx == act.startIdx && state == pco_pkg::S_RUN)
      else $error("cyclic pass did not wrap");
   a_skip_quiet: assert property (skip |-> !trig)
      else $error("skipped point triggered");
   a_pulse_end: assert property (actv && usTick && wcnt == 20'h00001 && !fire && en
      |=> !actv && lvl == act.idleHigh)
      else $error("pulse did not end on count");
   a_origin_set: assert property (originSet && en && !enRise |=> pos == act.origin)
      else $error("origin set did not load offset");
   a_bus_wait: assert property ((avRead || avWrite) && !ack |-> avWaitRequest ##1 !avWaitRequest)
      else $error("bus answer not in one wait cycle");
endmodule

// ### pco_pkg.sv
// Constants, types and register layout of the position compare output block
// Overview of operation
// - Compare live position, drive output after the set delay
// - Resolution code 0..10 halves counts per step
// - Mode bit0: absolute or incremental comparison
// - Mode bit1: single or cyclic pass, default 0
// - Settings take effect on enable rising edge
// - Output type selects idle and active level
// - Output form: timed pulse or held level
// - Pulse width 1..10000 units of 100 us; writes are not range-checked, any 14-bit value 0..16383 is kept
// - Output delay compensation 0..200 us; writes are not range-checked, any 8-bit value 0..255 is kept
// - Origin set loads position with offset
// - Start index default 1, end default 8
// - Pulse form attributes: skip, forward, backward, both
// - Level form attributes drive active or initial level
// - Each point holds signed 32-bit target
// - Pin assignment routes output to connector pin
package pco_pkg;
   // ======================================================
   // Register byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_MODE   = 8'h04;
   localparam logic [7:0] A_OUTCFG = 8'h08;
   localparam logic [7:0] A_PULSEW = 8'h0c;
   localparam logic [7:0] A_DELAY  = 8'h10;
   localparam logic [7:0] A_ORIGIN = 8'h14;
   localparam logic [7:0] A_START  = 8'h18;
   localparam logic [7:0] A_END    = 8'h1c;
   localparam logic [7:0] A_RES    = 8'h20;
   localparam logic [7:0] A_PIN    = 8'h24;
   localparam logic [7:0] A_STATUS = 8'h28;
   localparam logic [7:0] A_POS    = 8'h2c;
   localparam logic [7:0] A_PT     = 8'h40;
   localparam logic [7:0] A_PTEND  = 8'he0;
   // ======================================================
   // Field positions
   localparam int CTRL_EN     = 0;
   localparam int CTRL_ORIGIN = 1;
   localparam int MODE_INC    = 0;
   localparam int MODE_CYC    = 1;
   localparam int PT_TGT_SEL  = 2;
   // ======================================================
   // Ranges and reset values
   localparam int          NPTS      = 20;
   localparam logic [3:0]  RES_MAX   = 4'ha;
   localparam logic [3:0]  RES_DEF   = 4'h7;
   localparam logic [13:0] PW_DEF    = 14'h0064;
   localparam logic [4:0]  IDX_MIN   = 5'h01;
   localparam logic [4:0]  IDX_MAX   = 5'h14;
   localparam logic [4:0]  START_DEF = 5'h01;
   localparam logic [4:0]  END_DEF   = 5'h08;
   localparam logic [15:0] PIN_DEF   = 16'h0010;
   localparam logic [2:0]  AT_SKIP   = 3'h0;
   localparam logic [2:0]  AT_FWD    = 3'h1;
   localparam logic [2:0]  AT_BWD    = 3'h2;
   localparam logic [2:0]  AT_BOTH   = 3'h3;
   localparam logic [2:0]  AT_IFWD   = 3'h4;
   localparam logic [2:0]  AT_IBWD   = 3'h5;
   localparam logic [2:0]  AT_IBOTH  = 3'h6;
   localparam int          NPINS     = 14;
   // ======================================================
   // Timing
   localparam int CLK_NS  = 25;
   localparam int US_NS   = 1000;
   localparam int CYC_US  = (US_NS + CLK_NS - 1) / CLK_NS;
   localparam int UNIT_US = 100;
   // ======================================================
   // Types
   typedef struct packed {
      logic [1:0]  mode;
      logic        idleHigh;
      logic        levelForm;
      logic [13:0] pulseW;
      logic [7:0]  delay;
      logic [31:0] origin;
      logic [4:0]  startIdx;
      logic [4:0]  endIdx;
      logic [3:0]  res;
      logic [15:0] pinAssign;
   } pco_cfg_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_RUN  = 3'b010,
      S_DONE = 3'b100
   } pco_state_t;
endpackage

// ### pco_ctrl_model.sv
// Motion controller model that receives the compare output line
`timescale 1ns/100ps
module pco_ctrl_model
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic lineIn,
   input  wire logic idleHigh,
   output int        pulses,
   output int        lastWidth
);
   // ======================================================
   // Active level is the inverse of the idle level
   logic active;
   int   run;
   assign active = (lineIn !== idleHigh);
   // ======================================================
   // Count active phases and measure their length in cycles
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulses    <= 0;
         lastWidth <= 0;
         run       <= 0;
      end
      else if (active)
      begin
         if (run == 0)
            pulses <= pulses + 1;
         run <= run + 1;
      end
      else
      begin
         if (run != 0)
            lastWidth <= run;
         run <= 0;
      end
   end
endmodule

// ### position_compare_output_tb_top.sv
// Self-checking testbench of the position compare output block
`timescale 1ns/100ps
module position_compare_output_tb_top;
   logic                      clk;
   logic                      rst_n;
   logic [7:0]                avAddress;
   logic                      avRead;
   logic                      avWrite;
   logic [31:0]               avWriteData;
   logic [31:0]               avReadData;
   logic                      avWaitRequest;
   logic [31:0]               posIn;
   logic                      cmpOut;
   logic [pco_pkg::NPINS-1:0] pinOut;
   logic                      idleHigh;
   int                        pulses;
   int                        lastWidth;
   int                        err_count;
   int                        samples_checked;
   logic [31:0]               seed;
   logic [31:0]               q;
   int                        t;
   int                        n;
   int                        d;

   pco_position_compare dut (.clk(clk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead),
      .avWrite(avWrite), .avWriteData(avWriteData), .avReadData(avReadData),
      .avWaitRequest(avWaitRequest), .posIn(posIn), .cmpOut(cmpOut), .pinOut(pinOut));
   pco_ctrl_model ctrl (.clk(clk), .rst_n(rst_n), .lineIn(cmpOut), .idleHigh(idleHigh),
      .pulses(pulses), .lastWidth(lastWidth));

   // ======================================================
   // Clock, random source and expectation helpers
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic lvl(input logic idle, input logic act);
      return idle ^ act;
   endfunction
   // ======================================================
   // Checking and reporting
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ======================================================
   // Avalon-MM master
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk);
      avAddress   <= a;
      avWriteData <= dat;
      avWrite     <= wr;
      avRead      <= !wr;
      do
         @(posedge clk);
      while (avWaitRequest !== 1'b0);
      q = avReadData;
      avWrite <= 1'b0;
      avRead  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic pt(input int i, input logic [2:0] at, input logic [31:0] tg);
      bus(1'b1, pco_pkg::A_PT + 8'(8 * (i - 1)), {29'h0, at});
      bus(1'b1, pco_pkg::A_PT + 8'(8 * (i - 1) + 4), tg);
   endtask
   // Program settings, then raise enable so they are taken
   task automatic arm(input logic [1:0] cfg, input logic [1:0] md, input logic [7:0] dl,
                      input logic [3:0] rs, input logic [31:0] og, input logic [4:0] e);
      bus(1'b1, pco_pkg::A_CTRL, 32'h0);
      bus(1'b1, pco_pkg::A_OUTCFG, {30'h0, cfg});
      bus(1'b1, pco_pkg::A_MODE, {30'h0, md});
      bus(1'b1, pco_pkg::A_DELAY, {24'h0, dl});
      bus(1'b1, pco_pkg::A_RES, {28'h0, rs});
      bus(1'b1, pco_pkg::A_ORIGIN, og);
      bus(1'b1, pco_pkg::A_PULSEW, 32'h1);
      bus(1'b1, pco_pkg::A_END, {27'h0, e});
      posIn    <= 32'h0;
      idleHigh <= cfg[0];
      bus(1'b1, pco_pkg::A_CTRL, 32'h1);
      repeat (3) @(posedge clk);
   endtask
   task automatic move(input int p);
      @(posedge clk);
      posIn <= p;
      @(posedge clk);
      #1;
   endtask
   // ======================================================
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      avAddress = 8'h00;
      avRead = 1'b0;
      avWrite = 1'b0;
      avWriteData = 32'h0;
      posIn = 32'h0;
      idleHigh = 1'b0;
      err_count = 0;
      samples_checked = 0;
      seed = 32'hc325c628;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and refused writes
      chk({17'h0, cmpOut, pinOut}, 32'h0);
      rd(pco_pkg::A_RES, 32'h7);
      rd(pco_pkg::A_MODE, 32'h0);
      rd(pco_pkg::A_PULSEW, 32'h64);
      rd(pco_pkg::A_DELAY, 32'h0);
      rd(pco_pkg::A_ORIGIN, 32'h0);
      rd(pco_pkg::A_START, 32'h1);
      rd(pco_pkg::A_END, 32'h8);
      rd(pco_pkg::A_PIN, 32'h10);
      rd(pco_pkg::A_PT + 8'h04, 32'h0);
      rd(8'hfc, 32'h0);
      bus(1'b1, pco_pkg::A_START, 32'h15);
      rd(pco_pkg::A_START, 32'h1);
      bus(1'b1, pco_pkg::A_RES, 32'hb);
      rd(pco_pkg::A_RES, 32'h7);
      $display("reset and refusal test done");
      // Every pulse attribute, cyclic over one point, both idle levels
      for (int a = 0; a < 7; a++)
      begin
         t = 200 + int'(xorshift() % 800);
         pt(1, 3'(a), t);
         arm({1'b0, a[0]}, 2'b10, 8'h0, 4'h0, 32'h0, 5'h1);
         n = pulses;
         chk({31'h0, cmpOut}, {31'h0, lvl(a[0], 1'b0)});
         move(t - 1);
         move(t + 1);
         chk({31'h0, cmpOut}, {31'h0, lvl(a[0], a == 1 || a == 3)});
         repeat (4100) @(posedge clk);
         if (a == 1 || a == 3)
            chk(32'(lastWidth >= 3960 && lastWidth <= 4001), 32'h1);
         move(t - 2);
         chk({31'h0, cmpOut}, {31'h0, lvl(a[0], a == 2 || a == 3)});
         repeat (4100) @(posedge clk);
         chk(32'(pulses - n), 32'(((a == 1 || a == 3) ? 1 : 0) + ((a == 2 || a == 3) ? 1 : 0)));
      end
      $display("pulse attribute test done");
      // Level form, idle high, routed to pin 5, single pass over two points
      t = 300 + int'(xorshift() % 500);
      pt(1, pco_pkg::AT_FWD, t);
      pt(2, pco_pkg::AT_IBWD, t - 50);
      bus(1'b1, pco_pkg::A_PIN, 32'h50);
      arm(2'b11, 2'b00, 8'h0, 4'h0, 32'h0, 5'h2);
      chk({17'h0, cmpOut, pinOut}, {17'h0, 1'b1, 14'h0020});
      move(t + 1);
      chk({17'h0, cmpOut, pinOut}, 32'h0);
      move(t - 100);
      chk({31'h0, cmpOut}, 32'h1);
      move(t + 1);
      chk({31'h0, cmpOut}, 32'h1);
      bus(1'b0, pco_pkg::A_STATUS, 32'h0);
      chk({31'h0, q[1]}, 32'h1);
      $display("level form test done");
      // Delay compensation
      d = 1 + int'(xorshift() % 8);
      pt(1, pco_pkg::AT_FWD, 32'd100);
      arm(2'b00, 2'b00, 8'(d), 4'h0, 32'h0, 5'h1);
      move(101);
      n = 1;
      while (cmpOut !== 1'b1 && n < 500)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(n >= 40 * d && n <= 40 * d + 41), 32'h1);
      $display("delay test done");
      // Incremental single pass: point 2 is relative to the point 1 hit
      pt(2, pco_pkg::AT_FWD, 32'd40);
      arm(2'b00, 2'b01, 8'h0, 4'h0, 32'h0, 5'h2);
      move(101);
      move(120);
      rd(pco_pkg::A_STATUS, 32'h215);
      move(150);
      rd(pco_pkg::A_STATUS, 32'h216);
      $display("incremental test done");
      // Origin offset, resolution shift, settings held until enable rises
      arm(2'b00, 2'b00, 8'h0, 4'h4, 32'd1000, 5'h1);
      rd(pco_pkg::A_POS, 32'd1000);
      move(160);
      rd(pco_pkg::A_POS, 32'd1010);
      bus(1'b1, pco_pkg::A_ORIGIN, 32'd5);
      bus(1'b1, pco_pkg::A_CTRL, 32'h3);
      rd(pco_pkg::A_POS, 32'd1000);
      $display("origin test done");
      end_of_test();
   end
   // ======================================================
   // Watchdog
   initial
   begin
      repeat (80000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule
